//--- include/camdc_regs.svh
// Register offsets, field positions, reset values and counts for the core datapath.
// Assumes a 4-bit register port address and 16-bit register data.
`ifndef CAMDC_REGS_SVH
`define CAMDC_REGS_SVH
`define CAMDC_ADDR_W 4
`define CAMDC_CORE_CONTROL_OFS 4'h0
`define CAMDC_CPU_FLAGS_OFS 4'h1
`define CAMDC_CORE_CONTROL_RST 16'h0000
`define CAMDC_CORE_CONTROL_WMASK 16'h10f7
`define CAMDC_FLAGS_RST 5'h00
`define CAMDC_BIT_INT_MODE 0
`define CAMDC_BIT_ROUND 1
`define CAMDC_BIT_PROG_WIN 2
`define CAMDC_BIT_PRIO_MSB 3
`define CAMDC_BIT_ACC_SAT_MODE 4
`define CAMDC_BIT_STORE_SAT 5
`define CAMDC_BIT_SAT_B 6
`define CAMDC_BIT_SAT_A 7
`define CAMDC_NEST_LSB 8
`define CAMDC_NEST_MSB 10
`define CAMDC_BIT_EARLY_EXIT 11
`define CAMDC_BIT_MUL_SIGN 12
`define CAMDC_PRIO_LOW_MAX 4'h7
`define CAMDC_DIV_CYCLES 5'h10
`endif

//--- include/camdc_pkg.sv
// Types shared by the core datapath and whatever drives it.
// Assumes the decode stage builds requests in these layouts.
package camdc_pkg;
    typedef enum logic [3:0] {
        ALU_ADD = 4'h0, ALU_ADDC = 4'h1, ALU_SUB = 4'h2, ALU_SUBB = 4'h3,
        ALU_AND = 4'h4, ALU_IOR = 4'h5, ALU_XOR = 4'h6, ALU_SHL = 4'h7,
        ALU_LSR = 4'h8, ALU_ASR = 4'h9
    } camdc_alu_op_t;
    typedef enum logic [2:0] {
        MUL_SS = 3'h0, MUL_UU = 3'h1, MUL_US = 3'h2,
        MUL_SLIT = 3'h3, MUL_ULIT = 3'h4, MUL_BYTE = 3'h5
    } camdc_mul_mode_t;
    typedef enum logic {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} camdc_div_state_t;
    typedef struct packed {
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
    } camdc_flags_t;
    typedef struct packed {
        camdc_alu_op_t op;
        logic byte_mode;
        logic dst_mem;
        logic [15:0] a;
        logic [15:0] b;
    } camdc_alu_req_t;
    typedef struct packed {
        camdc_mul_mode_t mode;
        logic [15:0] a;
        logic [15:0] b;
    } camdc_mul_req_t;
    typedef struct packed {
        logic is_signed;
        logic is_long;
        logic [31:0] dividend;
        logic [15:0] divisor;
    } camdc_div_req_t;
endpackage

//--- logic/camdc_core.sv
// Integer datapath of the core: ALU with flags, MCU multiply, iterative divider,
// and the core control register. Assumes decode fetches operands and writes back.
// Function
// [RQ1] 16-bit ALU: add, subtract, shift, logic
// [RQ2] Arithmetic is two's complement
// [RQ3] ALU updates carry, zero, negative, overflow, digit-carry
// [RQ4] Subtract: carry and digit-carry mean no-borrow
// [RQ5] Byte or word width per instruction
// [RQ6] Operands from registers or memory, results back
// [RQ7] Multiply on shared 17x17 signed multiplier
// [RQ8] Signed, unsigned, mixed, literal and byte multiplies
// [RQ9] Signed/unsigned 32/16 and 16/16 divide
// [RQ10] Quotient to register zero, remainder to one
// [RQ11] Divisor any register, dividend aligned register pair
// [RQ12] One cycle per divisor bit, same length
// [RQ13] Early loop exit: write one pulses, reads zero
// [RQ14] Read-only three-bit loop nesting level
// [RQ15] Separate saturation enables for accumulators A, B
// [RQ16] Read-only priority level top bit, set above seven
// [RQ17] Program window enable bit maps program space
// [RQ18] Rounding select: biased when set, convergent clear
// [RQ19] Integer or fractional DSP multiply select
// [RQ20] Signed or unsigned DSP multiply select
// [RQ21] Top three control bits read zero
`timescale 1ns/1ps
`include "camdc_regs.svh"
module camdc_core
    import camdc_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [`CAMDC_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // ALU request and result
    input wire logic alu_valid,
    input wire camdc_alu_req_t alu_req,
    output logic alu_res_valid,
    output logic [15:0] alu_result,
    output logic alu_res_dst_mem,
    output camdc_flags_t flags_out,
    // Multiply request and result
    input wire logic mul_valid,
    input wire camdc_mul_req_t mul_req,
    output logic mul_res_valid,
    output logic [31:0] mul_result,
    // Divide request and result
    input wire logic div_valid,
    input wire camdc_div_req_t div_req,
    output logic div_busy,
    output logic div_done,
    output logic div_error,
    output logic [15:0] quotient_reg,
    output logic [15:0] remainder_reg,
    // Status from loop and interrupt logic
    input wire logic [2:0] loop_nest_level,
    input wire logic [3:0] cpu_prio_level,
    // Control to DSP engine, loop unit and address map
    output logic loop_early_exit,
    output logic mul_sign_select,
    output logic dsp_int_mode,
    output logic acc_a_sat_en,
    output logic acc_b_sat_en,
    output logic dsp_store_sat_en,
    output logic acc_sat_mode,
    output logic prog_window_en,
    output logic round_select
);
    // The datapath is written for a 16-bit word only; refused at elaboration
    if (DATA_W != 16) begin : g_bad_data_w
        $error("camdc_core supports DATA_W of 16 only");
    end

    // Conditional two's complement negate, shared by the divider stages
    function automatic logic [15:0] neg16(input logic n, input logic [15:0] v);
        neg16 = n ? 16'(~v + 16'h0001) : v;
    endfunction
    function automatic logic [31:0] neg32(input logic n, input logic [31:0] v);
        neg32 = n ? 32'(~v + 32'h00000001) : v;
    endfunction

    logic [15:0] ctrl_reg;
    camdc_flags_t flags_reg;
    logic ctrl_hit;
    assign ctrl_hit = reg_addr == `CAMDC_CORE_CONTROL_OFS;

    // Core control register; read-only and unused bits never store
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= `CAMDC_CORE_CONTROL_RST;
        end else if (reg_wr && ctrl_hit) begin
            ctrl_reg <= reg_wdata & `CAMDC_CORE_CONTROL_WMASK; // RQ21
        end
    end
    assign mul_sign_select = ctrl_reg[`CAMDC_BIT_MUL_SIGN]; // RQ20
    assign dsp_int_mode = ctrl_reg[`CAMDC_BIT_INT_MODE]; // RQ19
    assign acc_a_sat_en = ctrl_reg[`CAMDC_BIT_SAT_A]; // RQ15
    assign acc_b_sat_en = ctrl_reg[`CAMDC_BIT_SAT_B]; // RQ15
    assign dsp_store_sat_en = ctrl_reg[`CAMDC_BIT_STORE_SAT];
    assign acc_sat_mode = ctrl_reg[`CAMDC_BIT_ACC_SAT_MODE];
    assign prog_window_en = ctrl_reg[`CAMDC_BIT_PROG_WIN]; // RQ17
    assign round_select = ctrl_reg[`CAMDC_BIT_ROUND]; // RQ18

    // Early exit is a strobe, not storage, so it can never read back
    always_ff @(posedge clk) begin
        if (srst) begin
            loop_early_exit <= 1'b0;
        end else begin
            loop_early_exit <= reg_wr && ctrl_hit && reg_wdata[`CAMDC_BIT_EARLY_EXIT]; // RQ13
        end
    end

    // Read data: live status merged in, unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd && ctrl_hit) begin
            reg_rdata <= ctrl_reg; // RQ21
            reg_rdata[`CAMDC_NEST_MSB:`CAMDC_NEST_LSB] <= loop_nest_level; // RQ14
            reg_rdata[`CAMDC_BIT_PRIO_MSB] <= cpu_prio_level > `CAMDC_PRIO_LOW_MAX; // RQ16
        end else if (reg_rd && reg_addr == `CAMDC_CPU_FLAGS_OFS) begin
            reg_rdata <= {11'h000, flags_reg};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ALU combinational core
    logic [15:0] bx;
    logic cin;
    logic [16:0] sum;
    logic [4:0] nib;
    logic [8:0] lob;
    logic [15:0] res;
    logic msb_a;
    logic msb_b;
    logic msb_r;
    camdc_flags_t fl;
    always_comb begin
        bx = alu_req.b;
        cin = 1'b0;
        // Subtract adds the complement; carry out is then no-borrow
        case (alu_req.op)
            ALU_ADDC: cin = flags_reg.c;
            ALU_SUB: begin
                bx = ~alu_req.b; // RQ4
                cin = 1'b1;
            end
            ALU_SUBB: begin
                bx = ~alu_req.b; // RQ4
                cin = flags_reg.c;
            end
            default: cin = 1'b0;
        endcase
        sum = {1'b0, alu_req.a} + {1'b0, bx} + {16'h0000, cin}; // RQ1 RQ2
        nib = {1'b0, alu_req.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        lob = {1'b0, alu_req.a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
        case (alu_req.op)
            ALU_AND: res = alu_req.a & alu_req.b; // RQ1
            ALU_IOR: res = alu_req.a | alu_req.b;
            ALU_XOR: res = alu_req.a ^ alu_req.b;
            ALU_SHL: res = {alu_req.a[14:0], 1'b0};
            ALU_LSR: res = alu_req.byte_mode ? {alu_req.a[15:8], 1'b0, alu_req.a[7:1]}
                                              : {1'b0, alu_req.a[15:1]};
            ALU_ASR: res = alu_req.byte_mode ? {alu_req.a[15:8], alu_req.a[7], alu_req.a[7:1]}
                                              : {alu_req.a[15], alu_req.a[15:1]};
            default: res = sum[15:0];
        endcase
        // Byte operations leave the upper byte of the destination alone
        if (alu_req.byte_mode) begin
            res[15:8] = alu_req.a[15:8]; // RQ5
        end
        msb_a = alu_req.byte_mode ? alu_req.a[7] : alu_req.a[15];
        msb_b = alu_req.byte_mode ? bx[7] : bx[15];
        msb_r = alu_req.byte_mode ? res[7] : res[15];
        fl = flags_reg;
        fl.z = alu_req.byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000); // RQ3
        fl.n = msb_r;
        case (alu_req.op)
            ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB: begin
                fl.c = alu_req.byte_mode ? lob[8] : sum[16]; // RQ3 RQ4
                fl.dc = nib[4];
                fl.ov = (msb_a == msb_b) && (msb_r != msb_a);
            end
            ALU_SHL: fl.c = msb_a;
            ALU_LSR, ALU_ASR: fl.c = alu_req.a[0];
            default: fl.c = flags_reg.c;
        endcase
    end

    // Flag register and result stage
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_reg <= `CAMDC_FLAGS_RST;
        end else if (alu_valid) begin
            flags_reg <= fl; // RQ3
        end
    end
    assign flags_out = flags_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            alu_res_valid <= 1'b0;
            alu_result <= 16'h0000;
            alu_res_dst_mem <= 1'b0;
        end else begin
            alu_res_valid <= alu_valid;
            if (alu_valid) begin
                alu_result <= res;
                alu_res_dst_mem <= alu_req.dst_mem; // RQ6
            end
        end
    end

    // Multiply: each operand extended to 17 bits, then one signed product
    logic [16:0] mx;
    logic [16:0] my;
    logic signed [33:0] prod;
    always_comb begin
        mx = {1'b0, mul_req.a};
        my = {1'b0, mul_req.b};
        case (mul_req.mode)
            MUL_SS: begin
                mx = {mul_req.a[15], mul_req.a}; // RQ8
                my = {mul_req.b[15], mul_req.b};
            end
            MUL_US: my = {mul_req.b[15], mul_req.b};
            MUL_SLIT: begin
                mx = {mul_req.a[15], mul_req.a};
                my = {12'h000, mul_req.b[4:0]};
            end
            MUL_ULIT: my = {12'h000, mul_req.b[4:0]};
            MUL_BYTE: begin
                mx = {9'h000, mul_req.a[7:0]};
                my = {9'h000, mul_req.b[7:0]};
            end
            default: mx = {1'b0, mul_req.a};
        endcase
        prod = $signed(mx) * $signed(my); // RQ7
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            mul_res_valid <= 1'b0;
            mul_result <= 32'h00000000;
        end else begin
            mul_res_valid <= mul_valid;
            if (mul_valid) begin
                mul_result <= prod[31:0];
            end
        end
    end

    // Divider set-up: magnitudes, result signs and overflow check
    camdc_div_state_t div_state;
    logic [4:0] div_cnt;
    logic [15:0] dv_rem;
    logic [15:0] dv_sh;
    logic [15:0] dv_dvs;
    logic dv_neg_q;
    logic dv_neg_r;
    logic dv_err;
    logic dvd_sign;
    logic [31:0] dvd_full;
    logic [31:0] dvd_mag;
    logic [15:0] dvs_mag;
    logic [16:0] trial;
    logic ge;
    always_comb begin
        dvd_sign = div_req.is_long ? div_req.dividend[31] : div_req.dividend[15];
        dvd_full = div_req.is_long ? div_req.dividend // RQ11
                 : {{16{div_req.is_signed & div_req.dividend[15]}}, div_req.dividend[15:0]};
        dvd_mag = neg32(div_req.is_signed & dvd_sign, dvd_full); // RQ9
        dvs_mag = neg16(div_req.is_signed & div_req.divisor[15], div_req.divisor);
        trial = {dv_rem, dv_sh[15]};
        ge = trial >= {1'b0, dv_dvs};
    end
    assign div_busy = div_state == DIV_RUN;

    // Restoring divide, one quotient bit per cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            div_state <= DIV_IDLE;
            div_cnt <= 5'h00;
            dv_rem <= 16'h0000;
            dv_sh <= 16'h0000;
            dv_dvs <= 16'h0000;
            dv_neg_q <= 1'b0;
            dv_neg_r <= 1'b0;
            dv_err <= 1'b0;
        end else begin
            case (div_state)
                DIV_IDLE: begin
                    // A request during a divide is not taken
                    if (div_valid) begin
                        div_state <= DIV_RUN;
                        div_cnt <= 5'h00;
                        dv_rem <= dvd_mag[31:16];
                        dv_sh <= dvd_mag[15:0];
                        dv_dvs <= dvs_mag;
                        dv_neg_q <= div_req.is_signed & (dvd_sign ^ div_req.divisor[15]);
                        dv_neg_r <= div_req.is_signed & dvd_sign;
                        dv_err <= dvd_mag[31:16] >= dvs_mag;
                    end
                end
                DIV_RUN: begin
                    dv_rem <= ge ? 16'(trial - {1'b0, dv_dvs}) : trial[15:0];
                    dv_sh <= {dv_sh[14:0], ge};
                    div_cnt <= 5'(div_cnt + 5'h01);
                    if (div_cnt == `CAMDC_DIV_CYCLES - 5'h01) begin
                        div_state <= DIV_IDLE; // RQ12
                    end
                end
                default: div_state <= DIV_IDLE;
            endcase
        end
    end

    // Results land in the quotient and remainder registers together
    always_ff @(posedge clk) begin
        if (srst) begin
            div_done <= 1'b0;
            div_error <= 1'b0;
            quotient_reg <= 16'h0000;
            remainder_reg <= 16'h0000;
        end else begin
            div_done <= 1'b0;
            if (div_busy && div_cnt == `CAMDC_DIV_CYCLES - 5'h01) begin
                div_done <= 1'b1;
                div_error <= dv_err;
                quotient_reg <= neg16(dv_neg_q, {dv_sh[14:0], ge}); // RQ10
                remainder_reg <= neg16(dv_neg_r,
                    ge ? 16'(trial - {1'b0, dv_dvs}) : trial[15:0]); // RQ10
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_RSVD_ZERO: // RQ21
    assert property (reg_rdata[15:13] == 3'h0) else $error("reserved bits not zero");
    AST_EXIT_READS_ZERO: // RQ13
    assert property (reg_rd && ctrl_hit |=> !reg_rdata[`CAMDC_BIT_EARLY_EXIT])
        else $error("early exit bit read as one");
    AST_EXIT_PULSE: // RQ13
    assert property (reg_wr && ctrl_hit && reg_wdata[`CAMDC_BIT_EARLY_EXIT]
        |=> loop_early_exit ##1 !loop_early_exit || $past(reg_wr)) else $error("exit pulse bad");
    AST_NEST_READ: // RQ14
    assert property (reg_rd && ctrl_hit
        |=> reg_rdata[`CAMDC_NEST_MSB:`CAMDC_NEST_LSB] == $past(loop_nest_level))
        else $error("nesting level wrong");
    AST_PRIO_MSB: // RQ16
    assert property (reg_rd && ctrl_hit
        |=> reg_rdata[`CAMDC_BIT_PRIO_MSB] == ($past(cpu_prio_level) > 4'h7))
        else $error("priority top bit wrong");
    AST_SAT_EN: // RQ15
    assert property (reg_wr && ctrl_hit
        |=> acc_a_sat_en == $past(reg_wdata[7]) && acc_b_sat_en == $past(reg_wdata[6]))
        else $error("saturation enables not written");
    AST_SUB_BORROW: // RQ4
    assert property (alu_valid && alu_req.op == ALU_SUB && !alu_req.byte_mode
        |=> flags_out.c == ($past(alu_req.a) >= $past(alu_req.b)))
        else $error("borrow flag wrong");
    AST_ZERO_FLAG: // RQ3
    assert property (alu_res_valid |-> flags_out.z == ($past(alu_req.byte_mode)
        ? alu_result[7:0] == 8'h00 : alu_result == 16'h0000)) else $error("zero flag wrong");
    AST_BYTE_KEEP: // RQ5
    assert property (alu_valid && alu_req.byte_mode
        |=> alu_result[15:8] == $past(alu_req.a[15:8])) else $error("upper byte changed");
    AST_MUL_UU: // RQ8
    assert property (mul_valid && mul_req.mode == MUL_UU
        |=> mul_result == $past(mul_req.a) * $past(mul_req.b)) else $error("unsigned product");
    AST_MUL_SS: // RQ7
    assert property (mul_valid && mul_req.mode == MUL_SS
        |=> $signed(mul_result) == $signed($past(mul_req.a)) * $signed($past(mul_req.b)))
        else $error("signed product wrong");
    AST_DIV_TIME: // RQ12
    assert property (div_valid && !div_busy
        |=> div_busy[*8] ##1 div_busy[*8] ##1 div_done && !div_busy)
        else $error("divide length wrong");
    AST_DIV_UNS: // RQ10
    assert property (div_valid && !div_busy && !div_req.is_signed && !div_req.is_long
        && div_req.divisor != 16'h0000 |-> ##17 quotient_reg == $past(div_req.dividend[15:0], 17)
        / $past(div_req.divisor, 17) && remainder_reg == $past(div_req.dividend[15:0], 17)
        % $past(div_req.divisor, 17)) else $error("quotient or remainder wrong");

    COV_DIV_LONG: cover property (div_valid && !div_busy && div_req.is_long ##17 div_done);
    COV_BYTE_SUB: cover property (alu_valid && alu_req.byte_mode && alu_req.op == ALU_SUB);
    COV_EXIT: cover property (loop_early_exit);
endmodule // camdc_core

//--- tb/camdc_decode_model.sv
// Decode-stage stand-in: working registers, divide issue, result write-back.
// Assumes the bench loads registers and raises go on the core clock.
`timescale 1ns/1ps
module camdc_decode_model
    import camdc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register load and divide issue
    input wire logic ld_en,
    input wire logic [3:0] ld_idx,
    input wire logic [15:0] ld_val,
    input wire logic go,
    input wire logic [3:0] sel_m,
    input wire logic [3:0] sel_n,
    input wire logic sgn,
    input wire logic lng,
    // Core divide port
    output logic div_valid,
    output camdc_div_req_t div_req,
    input wire logic div_done,
    input wire logic [15:0] quotient_reg,
    input wire logic [15:0] remainder_reg,
    // Registers zero and one
    output logic [15:0] w0,
    output logic [15:0] w1
);
    logic [15:0] w [16];
    logic [3:0] m_even;
    // Pair base forced even, upper register holds upper half
    assign m_even = {sel_m[3:1], 1'b0};
    assign div_valid = go;
    // Short dividend: upper half shows junk so a design that reads it is caught
    assign div_req = '{sgn, lng,
        {lng ? w[m_even + 4'h1] : ~w[m_even], w[m_even]}, w[sel_n]};
    // Quotient and remainder written back; they win over a load
    always_ff @(posedge clk) begin
        if (div_done) begin
            w[0] <= quotient_reg;
            w[1] <= remainder_reg;
        end else if (ld_en) begin
            w[ld_idx] <= ld_val;
        end
    end
    assign w0 = w[0];
    assign w1 = w[1];
endmodule // camdc_decode_model

//--- tb/core_alu_mul_div_control_tb_top.sv
// Self-checking bench: control register, ALU, multiply and divide.
// Assumes the decode model supplies divide operands and takes results.
`timescale 1ns/1ps
`include "camdc_regs.svh"
module core_alu_mul_div_control_tb_top
    import camdc_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, alu_result, quotient_reg, remainder_reg;
    logic alu_valid = 1'b0, mul_valid = 1'b0, alu_res_valid, alu_res_dst_mem, mul_res_valid;
    camdc_alu_req_t alu_req = '0;
    camdc_mul_req_t mul_req = '0;
    camdc_div_req_t div_req;
    camdc_flags_t flags_out;
    logic [31:0] mul_result;
    logic div_valid, div_busy, div_done, div_error, loop_early_exit, mul_sign_select;
    logic dsp_int_mode, acc_a_sat_en, acc_b_sat_en, dsp_store_sat_en, acc_sat_mode;
    logic prog_window_en, round_select;
    logic [2:0] loop_nest_level = 3'h0;
    logic [3:0] cpu_prio_level = 4'h0, ld_idx = 4'h0, dm = 4'h0, dn = 4'h0;
    logic [15:0] ld_val = 16'h0000, w0, w1;
    logic ld_en = 1'b0, go = 1'b0, sgn = 1'b0, lng = 1'b0;
    int failures = 0;
    int n_compared = 0;

    camdc_core dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .alu_valid, .alu_req, .alu_res_valid, .alu_result, .alu_res_dst_mem, .flags_out,
        .mul_valid, .mul_req, .mul_res_valid, .mul_result, .div_valid, .div_req, .div_busy,
        .div_done, .div_error, .quotient_reg, .remainder_reg, .loop_nest_level,
        .cpu_prio_level, .loop_early_exit, .mul_sign_select, .dsp_int_mode, .acc_a_sat_en,
        .acc_b_sat_en, .dsp_store_sat_en, .acc_sat_mode, .prog_window_en, .round_select);
    camdc_decode_model partner (.clk, .ld_en, .ld_idx, .ld_val, .go, .sel_m(dm),
        .sel_n(dn), .sgn, .lng, .div_valid, .div_req, .div_done, .quotient_reg,
        .remainder_reg, .w0, .w1);

    // 100 MHz core clock
    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One-cycle strobes; return in the cycle after the strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg read", e, reg_rdata);
    endtask
    task automatic t_regs();
        rd(`CAMDC_CORE_CONTROL_OFS, 16'h0000);
        rd(`CAMDC_CPU_FLAGS_OFS, 16'h0000);
        @(posedge clk);
        loop_nest_level <= 3'h5;
        cpu_prio_level <= 4'h8;
        wr(`CAMDC_CORE_CONTROL_OFS, 16'hffff);
        chk("exit pulse", 1, loop_early_exit);
        chk("ctl outs", 8'hff, {mul_sign_select, dsp_int_mode, acc_a_sat_en, acc_b_sat_en,
            dsp_store_sat_en, acc_sat_mode, prog_window_en, round_select});
        @(posedge clk);
        #1 chk("exit end", 0, loop_early_exit);
        rd(`CAMDC_CORE_CONTROL_OFS, 16'h15ff);
        @(posedge clk);
        loop_nest_level <= 3'h7;
        cpu_prio_level <= 4'h7;
        wr(`CAMDC_CORE_CONTROL_OFS, 16'h0800);
        chk("exit only", 9'h100, {loop_early_exit, mul_sign_select, dsp_int_mode,
            acc_a_sat_en, acc_b_sat_en, dsp_store_sat_en, acc_sat_mode, prog_window_en,
            round_select});
        rd(`CAMDC_CORE_CONTROL_OFS, 16'h0700);
        wr(`CAMDC_CORE_CONTROL_OFS, 16'h0042);
        chk("b and round", 9'h011, {loop_early_exit, mul_sign_select, dsp_int_mode,
            acc_a_sat_en, acc_b_sat_en, dsp_store_sat_en, acc_sat_mode, prog_window_en,
            round_select});
        wr(4'h5, 16'hffff);
        rd(4'h5, 16'h0000);
        rd(`CAMDC_CORE_CONTROL_OFS, 16'h0742);
    endtask
    // Low bit of op doubles as write-back target so both targets are seen
    task automatic al(input camdc_alu_op_t op, input logic bm, input logic [15:0] a, b,
                      er, input logic [4:0] ef, fm);
        @(posedge clk);
        alu_valid <= 1'b1;
        alu_req <= '{op, bm, op[0], a, b};
        @(posedge clk);
        alu_valid <= 1'b0;
        #1 chk("alu valid", 1, alu_res_valid);
        chk("alu result", er, alu_result);
        chk("alu flags", ef, flags_out & fm);
        chk("alu dst", op[0], alu_res_dst_mem);
    endtask
    task automatic mu(input camdc_mul_mode_t md, input logic [15:0] a, b,
                      input logic [31:0] e);
        @(posedge clk);
        mul_valid <= 1'b1;
        mul_req <= '{md, a, b};
        @(posedge clk);
        mul_valid <= 1'b0;
        #1 chk("mul valid", 1, mul_res_valid);
        chk("mul result", e, mul_result);
    endtask
    task automatic ld(input logic [3:0] i, input logic [15:0] v);
        @(posedge clk);
        ld_en <= 1'b1;
        ld_idx <= i;
        ld_val <= v;
        @(posedge clk);
        ld_en <= 1'b0;
    endtask
    // A second request with a zero divisor is offered while busy and must be ignored
    task automatic dv(input logic [3:0] m, n, input logic s, l,
                      input logic [15:0] eq, er, input logic ee);
        int k;
        @(posedge clk);
        go <= 1'b1;
        dm <= m;
        dn <= n;
        sgn <= s;
        lng <= l;
        @(posedge clk);
        go <= 1'b0;
        #1 k = 1;
        chk("div busy", 1, div_busy);
        while (div_done !== 1'b1 && k < 40) begin
            @(posedge clk);
            go <= (k == 3);
            dn <= (k == 3) ? 4'h6 : n;
            #1 k++;
        end
        if (k >= 40) begin
            failures++;
            give_verdict();
        end
        chk("div cycles", 17, k);
        chk("div error", ee, div_error);
        if (!ee) begin
            chk("quotient", eq, quotient_reg);
            chk("remainder", er, remainder_reg);
            @(posedge clk);
            #1 chk("w0 w1", {eq, er}, {w0, w1});
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        $display("register test done");
        al(ALU_ADD, 1'b0, 16'h7fff, 16'h0001, 16'h8000, 5'h1c, 5'h1f);
        al(ALU_ADD, 1'b0, 16'hffff, 16'h0001, 16'h0000, 5'h13, 5'h1f);
        al(ALU_ADDC, 1'b0, 16'h0000, 16'h0000, 16'h0001, 5'h00, 5'h1f);
        al(ALU_SUB, 1'b0, 16'h0005, 16'h0003, 16'h0002, 5'h11, 5'h1f);
        al(ALU_SUB, 1'b0, 16'h0003, 16'h0005, 16'hfffe, 5'h08, 5'h1f);
        al(ALU_SUBB, 1'b0, 16'h0005, 16'h0003, 16'h0001, 5'h11, 5'h1f);
        al(ALU_AND, 1'b0, 16'hf0f0, 16'h0ff0, 16'h00f0, 5'h00, 5'h0a);
        al(ALU_IOR, 1'b0, 16'h8000, 16'h0001, 16'h8001, 5'h08, 5'h0a);
        al(ALU_XOR, 1'b0, 16'haaaa, 16'haaaa, 16'h0000, 5'h02, 5'h0a);
        al(ALU_SHL, 1'b0, 16'h8001, 16'h0001, 16'h0002, 5'h01, 5'h0b);
        al(ALU_LSR, 1'b0, 16'h0003, 16'h0001, 16'h0001, 5'h01, 5'h0b);
        al(ALU_ASR, 1'b0, 16'h8000, 16'h0001, 16'hc000, 5'h08, 5'h0b);
        al(ALU_LSR, 1'b1, 16'h1281, 16'h0001, 16'h1240, 5'h01, 5'h0b);
        al(ALU_ASR, 1'b1, 16'h1281, 16'h0001, 16'h12c0, 5'h09, 5'h0b);
        al(ALU_ADD, 1'b1, 16'h12ff, 16'h0001, 16'h1200, 5'h03, 5'h0b);
        al(ALU_SUB, 1'b1, 16'h3480, 16'h0001, 16'h347f, 5'h05, 5'h0f);
        rd(`CAMDC_CPU_FLAGS_OFS, 16'h0005);
        $display("alu test done");
        mu(MUL_SS, 16'hffff, 16'h0002, 32'hfffffffe);
        mu(MUL_UU, 16'hffff, 16'h0002, 32'h0001fffe);
        mu(MUL_US, 16'hffff, 16'hffff, 32'hffff0001);
        mu(MUL_SLIT, 16'hfffe, 16'h0023, 32'hfffffffa);
        mu(MUL_ULIT, 16'hfffe, 16'h0023, 32'h0002fffa);
        mu(MUL_BYTE, 16'h12ff, 16'h34ff, 32'h0000fe01);
        $display("multiply test done");
        ld(4'h2, 16'h0000);
        ld(4'h3, 16'h0001);
        ld(4'h5, 16'h0002);
        ld(4'h6, 16'h0000);
        ld(4'h8, 16'hfff9);
        ld(4'ha, 16'hfff0);
        ld(4'hb, 16'hffff);
        dv(4'h3, 4'h5, 1'b0, 1'b1, 16'h8000, 16'h0000, 1'b0);
        dv(4'h8, 4'h5, 1'b1, 1'b0, 16'hfffd, 16'hffff, 1'b0);
        dv(4'h8, 4'h5, 1'b0, 1'b0, 16'h7ffc, 16'h0001, 1'b0);
        dv(4'ha, 4'h5, 1'b1, 1'b1, 16'hfff8, 16'h0000, 1'b0);
        dv(4'h8, 4'h6, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b1);
        $display("divide test done");
        give_verdict();
    end
endmodule // core_alu_mul_div_control_tb_top
